/* File: verilog/sarb_register_bank.sv */
/*
 * Byte-wide register bank of the acquisition device.
 * Assumes the I2C engine issues one-cycle wr_en_i/rd_en_i strobes with an
 * address, and that the analog chain returns a result with a done pulse.
 */
module sarb_register_bank (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // decoded register access from the serial engine
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o,
    output logic             rvalid_o,
    output logic             addr_hit_o,
    // general-purpose pads
    input  wire logic [3:0]  pad_in_i,
    output logic      [3:0]  pad_out_o,
    output logic      [3:0]  pad_oe_o,
    // conversion result interface
    input  wire logic [15:0] conv_result_i,
    input  wire logic        conv_done_i,
    output logic             conv_start_o,
    // configuration outputs
    output logic             oscillator_on_o,
    output logic             bus_timeout_en_o,
    output logic             pin_address_command_o,
    output logic [7:0]       cfg0_o,
    output logic [7:0]       cfg1_o,
    output logic [7:0]       cfg2_o,
    output logic [7:0]       cfg3_o,
    output logic [7:0]       cfg4_o,
    output logic [7:0]       cfg5_o,
    output logic [7:0]       mode_o
);
    // ==================================================================
    // register state
    logic [7:0]  osc_r,    osc_nxt;
    logic [7:0]  padout_r, padout_nxt;
    logic [7:0]  tmo_r,    tmo_nxt;
    logic [7:0]  extadr_r, extadr_nxt;
    logic [7:0]  cfg0_r,   cfg0_nxt;
    logic [7:0]  cfg1_r,   cfg1_nxt;
    logic [7:0]  cfg2_r,   cfg2_nxt;
    logic [7:0]  cfg3_r,   cfg3_nxt;
    logic [7:0]  cfg4_r,   cfg4_nxt;
    logic [7:0]  cfg5_r,   cfg5_nxt;
    logic [7:0]  mode_r,   mode_nxt;
    logic [15:0] result_r, result_nxt;
    logic        busy_r,   busy_nxt;
    logic        start_r,  start_nxt;
    logic        pinadr_r, pinadr_nxt;
    logic [7:0]  rdata_r,  rdata_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic        hit_r,    hit_nxt;
    logic [3:0]  pout_r,   pout_nxt;
    logic [3:0]  poe_r,    poe_nxt;
    logic        hit;
    logic        kick;

    // rule checks further down share this clock and reset
    default clocking a_clk @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    // ==================================================================
    // address decode
    always_comb begin
        case (addr_i)
            sarb_pkg::ADDR_OSC, sarb_pkg::ADDR_PADOUT, sarb_pkg::ADDR_PADIN,
            sarb_pkg::ADDR_TMO, sarb_pkg::ADDR_EXTADR, sarb_pkg::ADDR_RESLO,
            sarb_pkg::ADDR_RESHI, sarb_pkg::ADDR_CFG0, sarb_pkg::ADDR_CFG1,
            sarb_pkg::ADDR_CFG2, sarb_pkg::ADDR_CFG3, sarb_pkg::ADDR_CFG4,
            sarb_pkg::ADDR_CFG5, sarb_pkg::ADDR_MODE: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // ==================================================================
    // write path and conversion control
    always_comb begin
        osc_nxt    = osc_r;
        padout_nxt = padout_r;
        tmo_nxt    = tmo_r;
        extadr_nxt = extadr_r;
        cfg0_nxt   = cfg0_r;
        cfg1_nxt   = cfg1_r;
        cfg2_nxt   = cfg2_r;
        cfg3_nxt   = cfg3_r;
        cfg4_nxt   = cfg4_r;
        cfg5_nxt   = cfg5_r;
        mode_nxt   = mode_r;
        pinadr_nxt = pinadr_r;
        kick       = 1'b0;
        if (wr_en_i) begin
            case (addr_i)
                sarb_pkg::ADDR_OSC:    osc_nxt = wdata_i & sarb_pkg::WM_OSC;
                sarb_pkg::ADDR_PADOUT: padout_nxt = wdata_i;
                sarb_pkg::ADDR_TMO:    tmo_nxt = wdata_i & sarb_pkg::WM_TMO;
                sarb_pkg::ADDR_EXTADR: begin
                    extadr_nxt = wdata_i;
                    if (wdata_i == sarb_pkg::EXTADR_CMD) begin
                        pinadr_nxt = 1'b1;
                    end
                end
                sarb_pkg::ADDR_CFG0: begin
                    cfg0_nxt = wdata_i & sarb_pkg::WM_CFG0;
                    kick     = wdata_i[sarb_pkg::BIT_START];
                end
                sarb_pkg::ADDR_CFG1:   cfg1_nxt = wdata_i;
                sarb_pkg::ADDR_CFG2:   cfg2_nxt = wdata_i;
                sarb_pkg::ADDR_CFG3:   cfg3_nxt = wdata_i;
                sarb_pkg::ADDR_CFG4:   cfg4_nxt = wdata_i;
                sarb_pkg::ADDR_CFG5: begin
                    cfg5_nxt = wdata_i & sarb_pkg::WM_CFG5;
                    if (wdata_i[sarb_pkg::BIT_DEF]) begin
                        // default chain setup; channel and reference kept as written
                        cfg0_nxt = sarb_pkg::RST_CFG0;
                        cfg1_nxt = sarb_pkg::RST_CFG1;
                        cfg2_nxt = sarb_pkg::RST_CFG2;
                        cfg3_nxt = sarb_pkg::RST_CFG3;
                        cfg4_nxt = sarb_pkg::RST_CFG4;
                        kick     = 1'b1;
                    end
                end
                sarb_pkg::ADDR_MODE: mode_nxt = (wdata_i & sarb_pkg::WM_MODE)
                                              | (sarb_pkg::RST_MODE & ~sarb_pkg::WM_MODE);
                default: ;
            endcase
        end
    end

    // start pulse and busy flag; continuous mode re-launches on each result
    always_comb begin
        result_nxt = result_r;
        busy_nxt   = busy_r;
        start_nxt  = 1'b0;
        if (conv_done_i && busy_r) begin
            result_nxt = conv_result_i;
            busy_nxt   = 1'b0;
            if (cfg0_r[sarb_pkg::BIT_CONT]) begin
                start_nxt = 1'b1;
                busy_nxt  = 1'b1;
            end
        end
        // a new start wins over the clearing done
        if (kick) begin
            start_nxt = 1'b1;
            busy_nxt  = 1'b1;
        end
    end

    // ==================================================================
    // read path
    always_comb begin
        rdata_nxt  = 8'h00;
        rvalid_nxt = rd_en_i;
        hit_nxt    = (rd_en_i | wr_en_i) & hit;
        if (rd_en_i) begin
            case (addr_i)
                sarb_pkg::ADDR_OSC:    rdata_nxt = osc_r;
                sarb_pkg::ADDR_PADOUT: rdata_nxt = padout_r;
                sarb_pkg::ADDR_PADIN:  rdata_nxt = {4'h0, pad_in_i};
                sarb_pkg::ADDR_TMO:    rdata_nxt = tmo_r;
                sarb_pkg::ADDR_EXTADR: rdata_nxt = extadr_r;
                sarb_pkg::ADDR_RESLO:  rdata_nxt = result_r[7:0];
                sarb_pkg::ADDR_RESHI:  rdata_nxt = result_r[15:8];
                sarb_pkg::ADDR_CFG0:   rdata_nxt = cfg0_r;
                sarb_pkg::ADDR_CFG1:   rdata_nxt = cfg1_r;
                sarb_pkg::ADDR_CFG2:   rdata_nxt = cfg2_r;
                sarb_pkg::ADDR_CFG3:   rdata_nxt = cfg3_r;
                sarb_pkg::ADDR_CFG4:   rdata_nxt = cfg4_r;
                sarb_pkg::ADDR_CFG5:   rdata_nxt = {busy_r, cfg5_r[6:0]};
                sarb_pkg::ADDR_MODE:   rdata_nxt = mode_r;
                default:               rdata_nxt = 8'h00;
            endcase
        end
    end

    // ==================================================================
    // pad drive: direction high drives, reference modes take pads 0 and 1
    always_comb begin
        pout_nxt = padout_r[3:0];
        poe_nxt  = padout_r[7:4];
        if (padout_r[7:4] != 4'h0 && pinadr_r) begin
            // address pins become inputs once pin addressing is enabled
            poe_nxt[1:0] = 2'b00;
        end
        if (mode_r[sarb_pkg::BIT_REFD1_IN]) begin
            poe_nxt[1] = 1'b0;
        end
        if (mode_r[sarb_pkg::BIT_REFD0_OUT]) begin
            poe_nxt[0] = 1'b0;
        end
    end

    // ==================================================================
    // registers
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            osc_r    <= sarb_pkg::RST_OSC;
            padout_r <= sarb_pkg::RST_PADOUT;
            tmo_r    <= sarb_pkg::RST_TMO;
            extadr_r <= sarb_pkg::RST_EXTADR;
            cfg0_r   <= sarb_pkg::RST_CFG0;
            cfg1_r   <= sarb_pkg::RST_CFG1;
            cfg2_r   <= sarb_pkg::RST_CFG2;
            cfg3_r   <= sarb_pkg::RST_CFG3;
            cfg4_r   <= sarb_pkg::RST_CFG4;
            cfg5_r   <= sarb_pkg::RST_CFG5;
            mode_r   <= sarb_pkg::RST_MODE;
            result_r <= sarb_pkg::RST_RESULT;
            busy_r   <= 1'b0;
            start_r  <= 1'b0;
            pinadr_r <= 1'b0;
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
            hit_r    <= 1'b0;
            pout_r   <= 4'h0;
            poe_r    <= 4'h0;
        end else begin
            osc_r    <= osc_nxt;
            padout_r <= padout_nxt;
            tmo_r    <= tmo_nxt;
            extadr_r <= extadr_nxt;
            cfg0_r   <= cfg0_nxt;
            cfg1_r   <= cfg1_nxt;
            cfg2_r   <= cfg2_nxt;
            cfg3_r   <= cfg3_nxt;
            cfg4_r   <= cfg4_nxt;
            cfg5_r   <= cfg5_nxt;
            mode_r   <= mode_nxt;
            result_r <= result_nxt;
            busy_r   <= busy_nxt;
            start_r  <= start_nxt;
            pinadr_r <= pinadr_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            hit_r    <= hit_nxt;
            pout_r   <= pout_nxt;
            poe_r    <= poe_nxt;
        end
    end

    assign rdata_o               = rdata_r;
    assign rvalid_o              = rvalid_r;
    assign addr_hit_o            = hit_r;
    assign pad_out_o             = pout_r;
    assign pad_oe_o              = poe_r;
    assign conv_start_o          = start_r;
    assign oscillator_on_o       = osc_r[0];
    assign bus_timeout_en_o      = tmo_r[sarb_pkg::BIT_TMO];
    assign pin_address_command_o = pinadr_r;
    assign cfg0_o                = cfg0_r;
    assign cfg1_o                = cfg1_r;
    assign cfg2_o                = cfg2_r;
    assign cfg3_o                = cfg3_r;
    assign cfg4_o                = cfg4_r;
    assign cfg5_o                = {busy_r, cfg5_r[6:0]};
    assign mode_o                = mode_r;

    // ==================================================================
    // checks
    sequence s_start_write;
        wr_en_i && addr_i == sarb_pkg::ADDR_CFG0 && wdata_i[sarb_pkg::BIT_START];
    endsequence

    a_start_pulse_busy: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        s_start_write |=> conv_start_o && busy_r)
        else $error("start write did not launch a conversion");
    a_busy_clears_done: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        busy_r && conv_done_i && !kick && !cfg0_r[sarb_pkg::BIT_CONT] |=> !busy_r)
        else $error("busy flag not cleared after result");
    a_result_capture: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        busy_r && conv_done_i |=> result_r == $past(conv_result_i))
        else $error("result not captured");
    a_osc_reserved_zero: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        osc_r[7:1] == 7'h00)
        else $error("oscillator register reserved bits set");
    a_padin_read: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        rd_en_i && addr_i == sarb_pkg::ADDR_PADIN |=> rdata_o == {4'h0, $past(pad_in_i)})
        else $error("pad level readback wrong");
    a_pad1_ref_block: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        mode_r[sarb_pkg::BIT_REFD1_IN] |=> !pad_oe_o[1])
        else $error("pad1 driven while external reference input on");
    a_pad_dir_gate: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        !padout_r[7] |=> !pad_oe_o[3])
        else $error("pad3 driven while set as input");
    a_extadr_cmd: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        wr_en_i && addr_i == sarb_pkg::ADDR_EXTADR && wdata_i == sarb_pkg::EXTADR_CMD
        |=> pin_address_command_o)
        else $error("pin address command not taken");
    a_def_start: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        wr_en_i && addr_i == sarb_pkg::ADDR_CFG5 && wdata_i[sarb_pkg::BIT_DEF]
        |=> conv_start_o && cfg1_r == sarb_pkg::RST_CFG1)
        else $error("default command did not configure and start");

    // ==================================================================
    // rule checks on the default clock
    sequence s_result_done;
        busy_r && conv_done_i;
    endsequence
    sequence s_relaunch;
        conv_start_o && busy_r;
    endsequence

    a_cont_relaunch: assert property (
        s_result_done ##0 cfg0_r[sarb_pkg::BIT_CONT]
        |=> s_relaunch)
        else $error("continuous mode did not relaunch");
    a_reset_load: assert property (
        $rose(resetn_i)
        |-> osc_r == sarb_pkg::RST_OSC && padout_r == sarb_pkg::RST_PADOUT)
        else $error("register not at reset value");
    a_mode_reserved: assert property (
        mode_r[7:6] == 2'b10)
        else $error("mode reserved bits changed");
    a_pad0_ref_block: assert property (
        mode_r[sarb_pkg::BIT_REFD0_OUT]
        |=> !pad_oe_o[0])
        else $error("pad0 driven while reference out on");
    a_pad3_dir_out: assert property (
        padout_r[7]
        |=> pad_oe_o[3])
        else $error("pad3 not driven as output");
    a_pad_level_copy: assert property (
        1'b1
        |=> pad_out_o == $past(padout_r[3:0]))
        else $error("pad drive level wrong");
    a_osc_write: assert property (
        wr_en_i && addr_i == sarb_pkg::ADDR_OSC
        |=> oscillator_on_o == $past(wdata_i[0]))
        else $error("oscillator enable not written");
    a_timeout_write: assert property (
        wr_en_i && addr_i == sarb_pkg::ADDR_TMO
        |=> bus_timeout_en_o == $past(wdata_i[sarb_pkg::BIT_TMO]))
        else $error("bus timeout enable not written");
    a_unmapped_read: assert property (
        rd_en_i && !hit
        |=> rdata_o == 8'h00 && !addr_hit_o)
        else $error("unmapped read not refused");
    a_mapped_hit: assert property (
        (rd_en_i || wr_en_i) && hit
        |=> addr_hit_o)
        else $error("mapped access not flagged");
    a_start_not_stored: assert property (
        !cfg0_r[sarb_pkg::BIT_START])
        else $error("start bit stored");
    a_def_not_stored: assert property (
        !cfg5_r[sarb_pkg::BIT_DEF])
        else $error("default command bit stored");
    a_busy_readback: assert property (
        rd_en_i && addr_i == sarb_pkg::ADDR_CFG5
        |=> rdata_o[sarb_pkg::BIT_BUSY] == $past(busy_r))
        else $error("activity flag readback wrong");
    a_result_low: assert property (
        rd_en_i && addr_i == sarb_pkg::ADDR_RESLO
        |=> rdata_o == $past(result_r[7:0]))
        else $error("result low byte readback wrong");
    a_result_high: assert property (
        rd_en_i && addr_i == sarb_pkg::ADDR_RESHI
        |=> rdata_o == $past(result_r[15:8]))
        else $error("result high byte readback wrong");
    a_pinadr_sticky: assert property (
        pin_address_command_o
        |=> pin_address_command_o)
        else $error("pin address mode dropped");
    a_pinadr_pads_in: assert property (
        pin_address_command_o
        |=> pad_oe_o[1:0] == 2'b00)
        else $error("address pads driven");
    a_stage_enable_write: assert property (
        wr_en_i && addr_i == sarb_pkg::ADDR_CFG1
        |=> cfg1_o == $past(wdata_i))
        else $error("bias and stage enables not written");
endmodule : sarb_register_bank

/* File: verilog/sarb_pkg.sv */
/*
 * Constants for the sensor acquisition register bank: byte offsets, field
 * positions and reset values of every register.
 * Assumes an I2C protocol engine that presents decoded register accesses.
 */
// Functional notes
// - decode all listed addresses for read/write access
// - reset loads every listed reset value
// - 0x30 bit0 oscillator enable, resets one
// - 0x40 bits7:4 pad directions, reset one
// - 0x40 bits3:0 pad levels, gated by direction
// - pad1/pad0 drive blocked by reference enables
// - 0x41 returns live pad levels, upper zero
// - 0x42 bit5 bus timeout enable, resets zero
// - 0x96 to 0x43 selects pin address bits
// - result bytes at 0x50/0x51, read only
// - 0x52 bit7 written one starts conversion
// - 0x52 bits6:5 elementary count exponent, reset 01
// - 0x52 bits4:2 oversampling exponent, reset 010
// - 0x52 bit1 continuous mode, bit0 zero
// - 0x53 bias selects, both reset 11
// - 0x54 rate, second gain, second offset
// - 0x57 bit6 applies defaults, starts conversion
// - 0x57 bits5:1 input channel, reset zero
// - 0x57 bit0 reference select, reset zero
// - bias codes 00/01/11 quarter/half/full current
// - 0x53 bits3:0 stage enables, reset zero
package sarb_pkg;
    // ==================================================================
    // offsets
    localparam logic [7:0] ADDR_OSC    = 8'h30;
    localparam logic [7:0] ADDR_PADOUT = 8'h40;
    localparam logic [7:0] ADDR_PADIN  = 8'h41;
    localparam logic [7:0] ADDR_TMO    = 8'h42;
    localparam logic [7:0] ADDR_EXTADR = 8'h43;
    localparam logic [7:0] ADDR_RESLO  = 8'h50;
    localparam logic [7:0] ADDR_RESHI  = 8'h51;
    localparam logic [7:0] ADDR_CFG0   = 8'h52;
    localparam logic [7:0] ADDR_CFG1   = 8'h53;
    localparam logic [7:0] ADDR_CFG2   = 8'h54;
    localparam logic [7:0] ADDR_CFG3   = 8'h55;
    localparam logic [7:0] ADDR_CFG4   = 8'h56;
    localparam logic [7:0] ADDR_CFG5   = 8'h57;
    localparam logic [7:0] ADDR_MODE   = 8'h70;
    // ==================================================================
    // field positions and commands
    localparam int         BIT_TMO        = 5;
    localparam int         BIT_START      = 7;
    localparam int         BIT_CONT       = 1;
    localparam int         BIT_DEF        = 6;
    localparam int         BIT_BUSY       = 7;
    localparam int         BIT_REFD1_IN   = 0;
    localparam int         BIT_REFD0_OUT  = 1;
    localparam logic [7:0] EXTADR_CMD     = 8'h96;
    // ==================================================================
    // reset values (RST_CFG0 to RST_CFG4 also applied by the default-configuration command)
    localparam logic [7:0] RST_OSC    = 8'h01;
    localparam logic [7:0] RST_PADOUT = 8'hF0;
    localparam logic [7:0] RST_TMO    = 8'h00;
    localparam logic [7:0] RST_EXTADR = 8'h00;
    localparam logic [7:0] RST_CFG0   = 8'h28;
    localparam logic [7:0] RST_CFG1   = 8'hF0;
    localparam logic [7:0] RST_CFG2   = 8'h00;
    localparam logic [7:0] RST_CFG3   = 8'h0C;
    localparam logic [7:0] RST_CFG4   = 8'h00;
    localparam logic [7:0] RST_CFG5   = 8'h00;
    localparam logic [7:0] RST_MODE   = 8'h84;
    localparam logic [15:0] RST_RESULT = 16'h0000;
    // writable masks: reserved and read-only bits stay as reset; WM_TMO lets every bit of 0x42 be written
    localparam logic [7:0] WM_OSC  = 8'h01;
    localparam logic [7:0] WM_TMO  = 8'hFF;
    // start and default-configuration bits act as strobes and are never stored
    localparam logic [7:0] WM_CFG0 = 8'h7E;
    localparam logic [7:0] WM_CFG5 = 8'h3F;
    localparam logic [7:0] WM_MODE = 8'h3F;
endpackage : sarb_pkg

/* File: tb/sarb_analog_model.sv */
/*
 * Behavioural model of the acquisition chain behind the register bank:
 * answers each start pulse with a done pulse and a 16-bit result.
 * Assumes the bench supplies the result value and the fast/slow choice.
 */
module sarb_analog_model (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // control from the bench
    input  wire logic        slow_i,
    input  wire logic [15:0] value_i,
    // chain handshake
    input  wire logic        conv_start_i,
    output logic             conv_done_o,
    output logic      [15:0] conv_result_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0]  cnt_r;
    logic [15:0] last_r;
    // ==================================================================
    // conversion timer
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            cnt_r  <= 5'h00;
            last_r <= 16'h0000;
        end else if (conv_start_i) begin
            cnt_r <= slow_i ? 5'h0C : 5'h02;
        end else if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
        end
        if (conv_done_o) begin
            last_r <= value_i;
        end
    end
    assign conv_done_o   = (cnt_r == 5'h01);
    // bus released outside done: show the inverse so a stale sample is caught
    assign conv_result_o = conv_done_o ? value_i : ~last_r;
endmodule : sarb_analog_model

/* File: tb/test_sensor_adc_register_bank.sv */
/*
 * Self-checking bench of the register bank: decoded strobe accesses,
 * pad resolution against external resistors, conversion handshakes.
 * Assumes sarb_analog_model on the chain side.
 */
module test_sensor_adc_register_bank;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        wr_en_i = 1'b0;
    logic        rd_en_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [7:0]  wdata_i = 8'h00;
    logic [7:0]  rdata_o;
    logic        rvalid_o;
    logic        addr_hit_o;
    logic [3:0]  pad_in_i;
    logic [3:0]  pad_out_o;
    logic [3:0]  pad_oe_o;
    logic [3:0]  ext_lvl = 4'hA;
    logic [15:0] conv_result_i;
    logic        conv_done_i;
    logic        conv_start_o;
    logic        oscillator_on_o;
    logic        bus_timeout_en_o;
    logic        pin_address_command_o;
    logic [7:0]  cfg0_o, cfg1_o, cfg2_o, cfg3_o, cfg4_o, cfg5_o, mode_o;
    logic        slow = 1'b1;
    logic [15:0] value = 16'hBEEF;
    int          err_total = 0;
    int          cmp_count = 0;
    int          starts = 0;
    int          s0;
    logic [7:0]  rst_tab [14] = '{8'h01, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h28,
                                  8'hF0, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h84, 8'h00};
    logic [7:0]  adr_tab [14] = '{8'h30, 8'h40, 8'h42, 8'h43, 8'h50, 8'h51, 8'h52,
                                  8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h70, 8'h31};
    logic [7:0]  wr_tab [4] = '{8'h5A, 8'hA5, 8'h8C, 8'h33};
    always #25 mclk_i = ~mclk_i;
    // pads with external resistors: a released pad settles to ext_lvl
    for (genvar g = 0; g < 4; g++) begin : g_pad
        assign pad_in_i[g] = pad_oe_o[g] ? pad_out_o[g] : ext_lvl[g];
    end
    always @(posedge mclk_i) if (conv_start_o === 1'b1) starts++;
    sarb_register_bank i_dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .addr_hit_o(addr_hit_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
        .pad_oe_o(pad_oe_o), .conv_result_i(conv_result_i), .conv_done_i(conv_done_i),
        .conv_start_o(conv_start_o), .oscillator_on_o(oscillator_on_o),
        .bus_timeout_en_o(bus_timeout_en_o), .pin_address_command_o(pin_address_command_o),
        .cfg0_o(cfg0_o), .cfg1_o(cfg1_o), .cfg2_o(cfg2_o), .cfg3_o(cfg3_o),
        .cfg4_o(cfg4_o), .cfg5_o(cfg5_o), .mode_o(mode_o));
    sarb_analog_model i_chain (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .slow_i(slow), .value_i(value),
        .conv_start_i(conv_start_o), .conv_done_o(conv_done_i),
        .conv_result_o(conv_result_i));
    // ==================================================================
    // comparison and access tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        #1;
        wr_en_i = 1'b1;
        addr_i  = a;
        wdata_i = d;
        @(posedge mclk_i);
        #1;
        wr_en_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        @(posedge mclk_i);
        #1;
        rd_en_i = 1'b1;
        addr_i  = a;
        @(posedge mclk_i);
        #1;
        rd_en_i = 1'b0;
        chk($sformatf("rvalid at %h", a), 8'h01, {7'h00, rvalid_o});
        chk($sformatf("hit at %h", a), {7'h00, hit}, {7'h00, addr_hit_o});
        chk($sformatf("data at %h", a), exp, rdata_o);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : settle
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    initial begin : watchdog
        #(20000 * 50);
        err_total++;
        $display("[FAIL] watchdog expected end seen hang");
        print_verdict();
    end
    // ==================================================================
    // test sequence
    initial begin : main
        settle(4);
        resetn_i = 1'b1;
        for (int i = 0; i < 14; i++) rd(adr_tab[i], rst_tab[i], i < 13);
        chk("osc after reset", 8'h01, {7'h00, oscillator_on_o});
        rd(8'h41, 8'h00, 1'b1);
        wr(8'h30, 8'h00);
        chk("osc stopped", 8'h00, {7'h00, oscillator_on_o});
        rd(8'h30, 8'h00, 1'b1);
        wr(8'h30, 8'h01);
        wr(8'h42, 8'h20);
        chk("timeout on", 8'h01, {7'h00, bus_timeout_en_o});
        rd(8'h42, 8'h20, 1'b1);
        for (int i = 0; i < 4; i++) wr(8'h53 + i, wr_tab[i]);
        for (int i = 0; i < 4; i++) rd(8'h53 + i, wr_tab[i], 1'b1);
        chk("cfg1 out", 8'h5A, cfg1_o);
        chk("cfg2 out", 8'hA5, cfg2_o);
        chk("cfg3 out", 8'h8C, cfg3_o);
        chk("cfg4 out", 8'h33, cfg4_o);
        wr(8'h52, 8'h76);
        rd(8'h52, 8'h76, 1'b1);
        chk("cfg0 out", 8'h76, cfg0_o);
        wr(8'h52, 8'h28);
        // pads: outputs, inputs, then reference blocking
        wr(8'h40, 8'hFC);
        settle(1);
        chk("oe all out", 8'h0F, {4'h0, pad_oe_o});
        rd(8'h41, 8'h0C, 1'b1);
        chk("levels out", 8'h0C, {4'h0, pad_out_o});
        wr(8'h40, 8'h0F);
        settle(1);
        chk("oe all in", 8'h00, {4'h0, pad_oe_o});
        rd(8'h41, 8'h0A, 1'b1);
        wr(8'h40, 8'hF3);
        wr(8'h70, 8'h85);
        settle(1);
        chk("pad1 blocked", 8'h0D, {4'h0, pad_oe_o});
        wr(8'h70, 8'h86);
        settle(1);
        chk("pad0 blocked", 8'h0E, {4'h0, pad_oe_o});
        chk("mode out", 8'h86, mode_o);
        rd(8'h41, 8'h02, 1'b1);
        wr(8'h70, 8'h84);
        // single conversion, slow chain
        s0 = starts;
        wr(8'h52, 8'hA8);
        settle(1);
        chk("one start", 8'h01, 8'(starts - s0));
        rd(8'h57, 8'h80, 1'b1);
        chk("busy out", 8'h80, cfg5_o);
        settle(16);
        rd(8'h50, 8'hEF, 1'b1);
        rd(8'h51, 8'hBE, 1'b1);
        rd(8'h57, 8'h00, 1'b1);
        rd(8'h52, 8'h28, 1'b1);
        // continuous mode, fast chain
        slow  = 1'b0;
        value = 16'h1234;
        s0 = starts;
        wr(8'h52, 8'hAA);
        settle(30);
        chk("repeats", 8'h01, 8'((starts - s0) > 4));
        wr(8'h52, 8'h28);
        settle(10);
        s0 = starts;
        settle(20);
        chk("stopped", 8'h00, 8'(starts - s0));
        rd(8'h50, 8'h34, 1'b1);
        // default configuration command
        s0 = starts;
        wr(8'h57, 8'h7F);
        settle(6);
        chk("default start", 8'h01, 8'(starts - s0));
        for (int i = 6; i < 11; i++) rd(adr_tab[i], rst_tab[i], 1'b1);
        rd(8'h57, 8'h3F, 1'b1);
        chk("cfg5 out", 8'h3F, cfg5_o);
        chk("cfg0 default", 8'h28, cfg0_o);
        // pin address command
        wr(8'h40, 8'hFC);
        wr(8'h43, 8'h95);
        chk("no pin address", 8'h00, {7'h00, pin_address_command_o});
        wr(8'h43, 8'h96);
        settle(1);
        chk("pin address", 8'h01, {7'h00, pin_address_command_o});
        chk("address pads in", 8'h0C, {4'h0, pad_oe_o});
        print_verdict();
    end
endmodule : test_sensor_adc_register_bank
